// ### common/dma_transfer_engine_consts.vh
// Purpose: constants shared by the transfer engine and its testbench
// Assumes: byte addresses of 32 bits, register port with an 8-bit byte address
// Notes: all offsets are byte addresses of 32-bit words
`ifndef DMA_TRANSFER_ENGINE_CONSTS_VH
`define DMA_TRANSFER_ENGINE_CONSTS_VH

`define REG_READ_PACING 8'h00
`define REG_ERR_ENABLE 8'h04
`define REG_ERR_STATUS 8'h08
`define REG_ENGINE_STATUS 8'h0C

`define ERR_ENDPOINT 0
`define ERR_UNMAPPED 1
`define ERR_CONST_ALIGN 2

`define PACING_RESET 8'h00
`define ERR_ENABLE_RESET 3'h7

`define DEST_FIFO_DEPTH 3'h4
`define DATA_FIFO_BYTES 10'h100
`define MERGE_MAX_COUNT 16'h03FF
`define CONST_ALIGN_MASK 32'h0000001F

`endif

// ### hw/cmd_sizer.v
// Purpose: size of the next command of one side of the engine
// Assumes: burst size is a power of two from 1 to 256 bytes
// Notes: pure combinational, one copy per side
module cmd_sizer (
    input wire [31:0] i_addr,
    input wire [17:0] i_left,
    input wire [8:0] i_burst,
    input wire i_const_mode,
    output reg [8:0] o_size
);
    reg [8:0] to_bound;
    reg [8:0] offset;

    always @* begin
        offset = i_addr[8:0] & (i_burst - 9'h001);
        to_bound = i_const_mode ? i_burst : (i_burst - offset);
        // smaller of burst room and bytes left
        if (i_left < {9'h000, to_bound}) begin
            o_size = i_left[8:0];
        end else begin
            o_size = to_bound;
        end
    end
endmodule

// ### hw/dma_transfer_engine.v
// Purpose: data movement engine splitting move requests into read and write commands
// Assumes: byte and array counts nonzero; default burst size a power of two up to 256
// Notes: data bytes themselves travel outside; the engine tracks data-FIFO byte credit
//
// Decided for this implementation: the plain strobed port and the address map.
`include "dma_transfer_engine_consts.vh"
module dma_transfer_engine (
    input wire i_clock,
    input wire i_nrst,
    input wire i_req_valid,
    output wire o_req_ready,
    input wire [31:0] i_req_src_addr,
    input wire [31:0] i_req_dst_addr,
    input wire [15:0] i_req_array_byte_count,
    input wire [15:0] i_req_array_count,
    input wire [15:0] i_req_src_step,
    input wire [15:0] i_req_dst_step,
    input wire i_req_src_const,
    input wire i_req_dst_const,
    input wire [8:0] i_default_burst_size,
    output wire o_rd_valid,
    output wire [31:0] o_rd_addr,
    output wire [8:0] o_rd_size,
    input wire i_rd_ready,
    input wire i_rd_resp_valid,
    input wire [8:0] i_rd_resp_bytes,
    input wire i_rd_resp_err,
    output wire o_wr_valid,
    output wire [31:0] o_wr_addr,
    output wire [8:0] o_wr_size,
    input wire i_wr_ready,
    input wire i_wr_resp_valid,
    input wire i_wr_resp_err,
    output wire o_done,
    output wire o_err_int,
    input wire [7:0] i_reg_addr,
    input wire [31:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire i_reg_rd,
    output wire [31:0] o_reg_rdata
);
    // two-dimensional side collapses to one array
    function merge_ok;
        input [15:0] abc;
        input [15:0] cnt;
        input [15:0] step;
        input const_mode;
        input [8:0] burst;
        begin
            merge_ok = ({7'h00, burst} >= abc) && ((abc & (abc - 16'h0001)) == 16'h0000)
                && (step == abc) && (cnt <= `MERGE_MAX_COUNT) && !const_mode;
        end
    endfunction

    function [17:0] first_left;
        input merged;
        input [15:0] abc;
        input [15:0] cnt;
        reg [31:0] prod;
        begin
            prod = abc * cnt;
            first_left = merged ? prod[17:0] : {2'b00, abc};
        end
    endfunction

    function [31:0] step_ext;
        input [15:0] step;
        begin
            step_ext = {{16{step[15]}}, step};
        end
    endfunction

    reg req_ready_ff;
    reg [7:0] pacing_ff;
    reg [2:0] err_en_ff;
    reg [2:0] err_ff;
    reg err_int_ff;
    reg [31:0] rdata_ff;
    reg done_ff;

    // source active set
    reg src_busy_ff;
    reg [31:0] src_addr_ff;
    reg [31:0] src_base_ff;
    reg [17:0] src_left_ff;
    reg [15:0] src_arrays_ff;
    reg [15:0] src_abc_ff;
    reg [15:0] src_step_ff;
    reg src_const_ff;
    reg [7:0] pace_ff;
    reg rd_valid_ff;
    reg [31:0] rd_addr_ff;
    reg [8:0] rd_size_ff;

    // destination request FIFO and active entry
    reg [31:0] dq_addr [0:3];
    reg [15:0] dq_abc [0:3];
    reg [15:0] dq_cnt [0:3];
    reg [15:0] dq_step [0:3];
    reg dq_const [0:3];
    reg [1:0] dq_wptr_ff;
    reg [1:0] dq_rptr_ff;
    reg [2:0] dq_cnt_ff;
    reg dst_busy_ff;
    reg [31:0] dst_addr_ff;
    reg [31:0] dst_base_ff;
    reg [17:0] dst_left_ff;
    reg [15:0] dst_arrays_ff;
    reg [15:0] dst_abc_ff;
    reg [15:0] dst_step_ff;
    reg dst_const_ff;
    reg wr_valid_ff;
    reg [31:0] wr_addr_ff;
    reg [8:0] wr_size_ff;

    // data FIFO credit: reserved by reads, available once data lands
    reg [9:0] rsv_ff;
    reg [9:0] avail_ff;

    wire [8:0] src_size;
    wire [8:0] dst_size;
    wire accept;
    wire rd_load;
    wire wr_load;
    wire dst_start;
    wire src_last;
    wire dst_last;
    wire reg_hit;
    wire const_bad;
    wire src_merge;
    wire dst_merge;
    wire nxt_src_busy;
    wire [2:0] nxt_dq_cnt;
    wire [2:0] err_set;
    wire [2:0] nxt_err;
    wire [9:0] rd_resp_add;
    wire [17:0] src_rem;
    wire [17:0] dst_rem;

    cmd_sizer u_src_sizer (
        .i_addr(src_addr_ff),
        .i_left(src_left_ff),
        .i_burst(i_default_burst_size),
        .i_const_mode(src_const_ff),
        .o_size(src_size)
    );

    cmd_sizer u_dst_sizer (
        .i_addr(dst_addr_ff),
        .i_left(dst_left_ff),
        .i_burst(i_default_burst_size),
        .i_const_mode(dst_const_ff),
        .o_size(dst_size)
    );

    // requests only enter on our ready
    assign accept = i_req_valid && req_ready_ff;
    // each side judges its own merge
    assign src_merge = merge_ok(i_req_array_byte_count, i_req_array_count, i_req_src_step,
        i_req_src_const, i_default_burst_size);
    assign dst_merge = merge_ok(dq_abc[dq_rptr_ff], dq_cnt[dq_rptr_ff], dq_step[dq_rptr_ff],
        dq_const[dq_rptr_ff], i_default_burst_size);

    // zero count reads back to back
    // the byte-credit check keeps reads from overrunning the data FIFO
    assign rd_load = src_busy_ff && (!rd_valid_ff || i_rd_ready) && (pace_ff == 8'h00)
        && ((rsv_ff + {1'b0, src_size}) <= `DATA_FIFO_BYTES);
    // write only once its bytes are buffered
    // no pacing on the write side
    assign wr_load = dst_busy_ff && (!wr_valid_ff || i_wr_ready)
        && (avail_ff >= {1'b0, dst_size});
    assign dst_start = !dst_busy_ff && (dq_cnt_ff != 3'h0) && !done_ff;

    assign src_rem = src_left_ff - {9'h000, src_size};
    assign dst_rem = dst_left_ff - {9'h000, dst_size};
    assign src_last = rd_load && (src_rem == 18'h00000) && (src_arrays_ff <= 16'h0001);
    assign dst_last = wr_load && (dst_rem == 18'h00000) && (dst_arrays_ff <= 16'h0001);

    // source frees for next request before writes end
    assign nxt_src_busy = accept ? 1'b1 : (src_last ? 1'b0 : src_busy_ff);
    assign nxt_dq_cnt = dq_cnt_ff + {2'b00, accept} - {2'b00, dst_last};

    assign rd_resp_add = i_rd_resp_valid ? {1'b0, i_rd_resp_bytes} : 10'h000;

    assign reg_hit = (i_reg_addr == `REG_READ_PACING) || (i_reg_addr == `REG_ERR_ENABLE)
        || (i_reg_addr == `REG_ERR_STATUS) || (i_reg_addr == `REG_ENGINE_STATUS);
    assign const_bad = (i_req_src_const && (((i_req_src_addr & `CONST_ALIGN_MASK) != 32'h0)
        || (({16'h0000, i_req_src_step} & `CONST_ALIGN_MASK) != 32'h0)))
        || (i_req_dst_const && (((i_req_dst_addr & `CONST_ALIGN_MASK) != 32'h0)
        || (({16'h0000, i_req_dst_step} & `CONST_ALIGN_MASK) != 32'h0)));

    // each source gated by its own enable
    assign err_set[`ERR_ENDPOINT] = err_en_ff[`ERR_ENDPOINT]
        && ((i_rd_resp_valid && i_rd_resp_err) || (i_wr_resp_valid && i_wr_resp_err));
    assign err_set[`ERR_UNMAPPED] = err_en_ff[`ERR_UNMAPPED] && (i_reg_wr || i_reg_rd) && !reg_hit;
    assign err_set[`ERR_CONST_ALIGN] = err_en_ff[`ERR_CONST_ALIGN] && accept && const_bad;
    // sticky bits, write one clears, set wins
    assign nxt_err = err_set | (err_ff & ~((i_reg_wr && (i_reg_addr == `REG_ERR_STATUS))
        ? i_reg_wdata[2:0] : 3'h0));

    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            req_ready_ff <= 1'b0;
            pacing_ff <= `PACING_RESET;
            err_en_ff <= `ERR_ENABLE_RESET;
            err_ff <= 3'h0;
            err_int_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            done_ff <= 1'b0;
        end else begin
            // in flight bounded by FIFO depth
            req_ready_ff <= !nxt_src_busy && (nxt_dq_cnt < `DEST_FIFO_DEPTH);
            err_ff <= nxt_err;
            // pulse when an enabled bit newly sets
            err_int_ff <= |(nxt_err & ~err_ff);
            done_ff <= dst_last;
            if (i_reg_wr && (i_reg_addr == `REG_READ_PACING)) begin
                pacing_ff <= i_reg_wdata[7:0];
            end
            if (i_reg_wr && (i_reg_addr == `REG_ERR_ENABLE)) begin
                err_en_ff <= i_reg_wdata[2:0];
            end
            rdata_ff <= 32'h00000000;
            if (i_reg_rd) begin
                case (i_reg_addr)
                    `REG_READ_PACING: begin
                        rdata_ff <= {24'h000000, pacing_ff};
                    end
                    `REG_ERR_ENABLE: begin
                        rdata_ff <= {29'h00000000, err_en_ff};
                    end
                    `REG_ERR_STATUS: begin
                        rdata_ff <= {29'h00000000, err_ff};
                    end
                    `REG_ENGINE_STATUS: begin
                        rdata_ff <= {27'h0000000, dst_busy_ff, dq_cnt_ff, src_busy_ff};
                    end
                    default: begin
                        rdata_ff <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    // source side: read commands
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            src_busy_ff <= 1'b0;
            src_addr_ff <= 32'h00000000;
            src_base_ff <= 32'h00000000;
            src_left_ff <= 18'h00000;
            src_arrays_ff <= 16'h0000;
            src_abc_ff <= 16'h0000;
            src_step_ff <= 16'h0000;
            src_const_ff <= 1'b0;
            pace_ff <= 8'h00;
            rd_valid_ff <= 1'b0;
            rd_addr_ff <= 32'h00000000;
            rd_size_ff <= 9'h000;
        end else begin
            if (rd_valid_ff && i_rd_ready) begin
                rd_valid_ff <= 1'b0;
            end
            if (accept) begin
                src_busy_ff <= 1'b1;
                src_addr_ff <= i_req_src_addr;
                src_base_ff <= i_req_src_addr;
                src_left_ff <= first_left(src_merge, i_req_array_byte_count, i_req_array_count);
                src_arrays_ff <= src_merge ? 16'h0001 : i_req_array_count;
                src_abc_ff <= i_req_array_byte_count;
                src_step_ff <= i_req_src_step;
                src_const_ff <= i_req_src_const;
                pace_ff <= 8'h00;
            end else if (rd_load) begin
                rd_valid_ff <= 1'b1;
                rd_addr_ff <= src_addr_ff;
                rd_size_ff <= src_size;
                pace_ff <= pacing_ff;
                if (src_rem != 18'h00000) begin
                    src_left_ff <= src_rem;
                    if (!src_const_ff) begin
                        src_addr_ff <= src_addr_ff + {23'h000000, src_size};
                    end
                end else if (src_arrays_ff > 16'h0001) begin
                    src_arrays_ff <= src_arrays_ff - 16'h0001;
                    src_left_ff <= {2'b00, src_abc_ff};
                    src_base_ff <= src_base_ff + step_ext(src_step_ff);
                    src_addr_ff <= src_base_ff + step_ext(src_step_ff);
                end else begin
                    src_busy_ff <= 1'b0;
                end
            end else if (pace_ff != 8'h00) begin
                pace_ff <= pace_ff - 8'h01;
            end
        end
    end

    // destination request FIFO
    always @(posedge i_clock) begin
        if (accept) begin
            dq_addr[dq_wptr_ff] <= i_req_dst_addr;
            dq_abc[dq_wptr_ff] <= i_req_array_byte_count;
            dq_cnt[dq_wptr_ff] <= i_req_array_count;
            dq_step[dq_wptr_ff] <= i_req_dst_step;
            dq_const[dq_wptr_ff] <= i_req_dst_const;
        end
    end

    // destination side: write commands
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            dq_wptr_ff <= 2'h0;
            dq_rptr_ff <= 2'h0;
            dq_cnt_ff <= 3'h0;
            dst_busy_ff <= 1'b0;
            dst_addr_ff <= 32'h00000000;
            dst_base_ff <= 32'h00000000;
            dst_left_ff <= 18'h00000;
            dst_arrays_ff <= 16'h0000;
            dst_abc_ff <= 16'h0000;
            dst_step_ff <= 16'h0000;
            dst_const_ff <= 1'b0;
            wr_valid_ff <= 1'b0;
            wr_addr_ff <= 32'h00000000;
            wr_size_ff <= 9'h000;
        end else begin
            dq_cnt_ff <= nxt_dq_cnt;
            if (accept) begin
                dq_wptr_ff <= dq_wptr_ff + 2'h1;
            end
            if (wr_valid_ff && i_wr_ready) begin
                wr_valid_ff <= 1'b0;
            end
            if (dst_start) begin
                dst_busy_ff <= 1'b1;
                dst_addr_ff <= dq_addr[dq_rptr_ff];
                dst_base_ff <= dq_addr[dq_rptr_ff];
                dst_left_ff <= first_left(dst_merge, dq_abc[dq_rptr_ff], dq_cnt[dq_rptr_ff]);
                dst_arrays_ff <= dst_merge ? 16'h0001 : dq_cnt[dq_rptr_ff];
                dst_abc_ff <= dq_abc[dq_rptr_ff];
                dst_step_ff <= dq_step[dq_rptr_ff];
                dst_const_ff <= dq_const[dq_rptr_ff];
            end else if (wr_load) begin
                wr_valid_ff <= 1'b1;
                wr_addr_ff <= dst_addr_ff;
                wr_size_ff <= dst_size;
                if (dst_rem != 18'h00000) begin
                    dst_left_ff <= dst_rem;
                    if (!dst_const_ff) begin
                        dst_addr_ff <= dst_addr_ff + {23'h000000, dst_size};
                    end
                end else if (dst_arrays_ff > 16'h0001) begin
                    dst_arrays_ff <= dst_arrays_ff - 16'h0001;
                    dst_left_ff <= {2'b00, dst_abc_ff};
                    dst_base_ff <= dst_base_ff + step_ext(dst_step_ff);
                    dst_addr_ff <= dst_base_ff + step_ext(dst_step_ff);
                end else begin
                    dst_busy_ff <= 1'b0;
                    dq_rptr_ff <= dq_rptr_ff + 2'h1;
                end
            end
        end
    end

    // byte credit of the data FIFO
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rsv_ff <= 10'h000;
            avail_ff <= 10'h000;
        end else begin
            rsv_ff <= rsv_ff + (rd_load ? {1'b0, src_size} : 10'h000)
                - (wr_load ? {1'b0, dst_size} : 10'h000);
            avail_ff <= avail_ff + rd_resp_add - (wr_load ? {1'b0, dst_size} : 10'h000);
        end
    end

    assign o_req_ready = req_ready_ff;
    assign o_rd_valid = rd_valid_ff;
    assign o_rd_addr = rd_addr_ff;
    assign o_rd_size = rd_size_ff;
    assign o_wr_valid = wr_valid_ff;
    assign o_wr_addr = wr_addr_ff;
    assign o_wr_size = wr_size_ff;
    assign o_done = done_ff;
    assign o_err_int = err_int_ff;
    assign o_reg_rdata = rdata_ff;
endmodule

// ### test/dma_transfer_engine_checker.sv
// Purpose: port checks of the transfer engine
// Assumes: burst size held steady
// Notes: pacing and enables shadowed
module dma_transfer_engine_checker (
    input wire logic i_clock, i_nrst, i_req_valid, o_req_ready,
    input wire logic [8:0] i_default_burst_size,
    input wire logic o_rd_valid, i_rd_ready, i_rd_resp_valid, o_wr_valid, i_wr_ready,
    input wire logic [31:0] o_rd_addr,
    input wire logic [8:0] o_rd_size, i_rd_resp_bytes, o_wr_size,
    input wire logic o_done, o_err_int, i_reg_wr, i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata, o_reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    logic [7:0] pace_ff;
    logic [8:0] gap_ff;
    logic [2:0] en_ff;
    logic pv_ff, ph_ff;
    logic [31:0] landed_ff, spent_ff;
    wire rd_hs = o_rd_valid && i_rd_ready;
    wire wr_hs = o_wr_valid && i_wr_ready;
    // new read: a rise, or a reload after a take
    wire ld = o_rd_valid && (!pv_ff || ph_ff);
    wire [8:0] mask = i_default_burst_size - 9'h001;
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            {pace_ff, en_ff, gap_ff, pv_ff, ph_ff} <= {8'h00, 3'h7, 9'h1FF, 2'h0};
            {landed_ff, spent_ff} <= 64'h0;
        end else begin
            if (i_reg_wr && i_reg_addr == 8'h00) pace_ff <= i_reg_wdata[7:0];
            if (i_reg_wr && i_reg_addr == 8'h04) en_ff <= i_reg_wdata[2:0];
            gap_ff <= ld ? 9'h000 : (gap_ff == 9'h1FF ? gap_ff : gap_ff + 9'h001);
            {pv_ff, ph_ff} <= {o_rd_valid, rd_hs};
            if (i_rd_resp_valid) landed_ff <= landed_ff + {23'h0, i_rd_resp_bytes};
            if (wr_hs) spent_ff <= spent_ff + {23'h0, o_wr_size};
        end
    end
    property p_rd_max;
        o_rd_valid |-> o_rd_size != 9'h000 && o_rd_size <= i_default_burst_size;
    endproperty
    a_rd_max: assert property (p_rd_max) else $error("read over burst");
    property p_wr_max;
        o_wr_valid |-> o_wr_size != 9'h000 && o_wr_size <= i_default_burst_size;
    endproperty
    a_wr_max: assert property (p_wr_max) else $error("write over burst");
    property p_rd_bound;
        o_rd_valid |-> ({1'b0, o_rd_addr[8:0] & mask} + {1'b0, o_rd_size})
            <= {1'b0, i_default_burst_size};
    endproperty
    a_rd_bound: assert property (p_rd_bound) else $error("read crosses burst line");
    property p_rd_hold;
        o_rd_valid && !i_rd_ready |=> o_rd_valid && $stable(o_rd_addr) && $stable(o_rd_size);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read dropped");
    property p_wr_hold;
        o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_size);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write dropped");
    property p_pace;
        ld |-> gap_ff >= {1'b0, pace_ff};
    endproperty
    a_pace: assert property (p_pace) else $error("read inside pacing gap");
    property p_credit;
        wr_hs |-> landed_ff >= spent_ff + {23'h0, o_wr_size};
    endproperty
    a_credit: assert property (p_credit) else $error("write ahead of landed data");
    property p_take;
        i_req_valid && o_req_ready |=> !o_req_ready;
    endproperty
    a_take: assert property (p_take) else $error("ready kept after take");
    property p_rdata;
        !$past(i_reg_rd) |-> o_reg_rdata == 32'h0;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data out of cycle");
    property p_done;
        o_done |=> !o_done;
    endproperty
    a_done: assert property (p_done) else $error("completion not a pulse");
    property p_int;
        o_err_int |-> en_ff != 3'h0;
    endproperty
    a_int: assert property (p_int) else $error("interrupt while all off");
    c_paced: cover property (ld && pace_ff != 8'h00);
    c_full: cover property (rd_hs && o_rd_size == i_default_burst_size);
    c_done: cover property (o_done);
    c_int: cover property (o_err_int);
endmodule
bind dma_transfer_engine dma_transfer_engine_checker chk_u (.i_clock, .i_nrst, .i_req_valid,
    .o_req_ready, .i_default_burst_size, .o_rd_valid, .i_rd_ready, .i_rd_resp_valid,
    .o_wr_valid, .i_wr_ready, .o_rd_addr, .o_rd_size, .i_rd_resp_bytes, .o_wr_size, .o_done,
    .o_err_int, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata);

// ### test/endpoint_model.sv
// Purpose: read and write endpoints
// Assumes: one response per command, a cycle later
// Notes: ready wanders while stalling
module endpoint_model (
    input wire logic i_clock, i_nrst, i_stall, i_inject_err, i_rd_valid, i_wr_valid,
    input wire logic [8:0] i_rd_size,
    output logic o_rd_ready, o_rd_resp_valid, o_rd_resp_err, o_wr_ready,
    output logic o_wr_resp_valid, o_wr_resp_err,
    output logic [8:0] o_rd_resp_bytes
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] lfsr_ff;
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            lfsr_ff <= 8'h5A;
            {o_rd_ready, o_wr_ready, o_rd_resp_valid, o_wr_resp_valid} <= 4'h0;
            {o_rd_resp_err, o_wr_resp_err} <= 2'h0;
            o_rd_resp_bytes <= 9'h000;
        end else begin
            lfsr_ff <= {lfsr_ff[6:0], ^{lfsr_ff[7], lfsr_ff[5:3]}};
            o_rd_ready <= !i_stall || lfsr_ff[0];
            o_wr_ready <= !i_stall || lfsr_ff[2];
            o_rd_resp_valid <= i_rd_valid && o_rd_ready;
            o_rd_resp_err <= i_inject_err && i_rd_valid && o_rd_ready;
            // off-response bytes never a stale copy
            o_rd_resp_bytes <= (i_rd_valid && o_rd_ready) ? i_rd_size : ~o_rd_resp_bytes;
            o_wr_resp_valid <= i_wr_valid && o_wr_ready;
            o_wr_resp_err <= i_inject_err && i_wr_valid && o_wr_ready;
        end
    end
endmodule

// ### test/test_dma_transfer_engine.sv
// Purpose: bench of the transfer engine
// Assumes: burst of 32 bytes
// Notes: expected commands from a queue model
`include "dma_transfer_engine_consts.vh"
module test_dma_transfer_engine;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 0, i_nrst = 0, req_v = 0, sc = 0, dc = 0, rwr = 0, rrd = 0;
    logic stall = 0, inj = 0;
    logic [31:0] sa = 0, da = 0, wdat = 0, seed = 32'h00007BEC;
    logic [15:0] abc = 1, cnt = 1, ss = 0, ds = 0;
    logic [7:0] radr = 0;
    wire rdy, rv, rrdy, rsv, rse, wv, wrdy, wsv, wse, done, eint;
    wire [31:0] raddr, waddr, rdata;
    wire [8:0] rsz, rsb, wsz;
    int n_errors = 0, tests_run = 0, n_done = 0, n_sent = 0, n_int = 0;
    int last_hs = 0, min_gap, max_gap, cyc = 0, a, c;
    logic [40:0] exp_rd[$], exp_wr[$];
    always #2.5 i_clock = ~i_clock;
    dma_transfer_engine dut_u (.i_clock, .i_nrst, .i_req_valid(req_v), .o_req_ready(rdy),
        .i_req_src_addr(sa), .i_req_dst_addr(da), .i_req_array_byte_count(abc),
        .i_req_array_count(cnt), .i_req_src_step(ss), .i_req_dst_step(ds),
        .i_req_src_const(sc), .i_req_dst_const(dc), .i_default_burst_size(9'h020),
        .o_rd_valid(rv), .o_rd_addr(raddr), .o_rd_size(rsz), .i_rd_ready(rrdy),
        .i_rd_resp_valid(rsv), .i_rd_resp_bytes(rsb), .i_rd_resp_err(rse),
        .o_wr_valid(wv), .o_wr_addr(waddr), .o_wr_size(wsz), .i_wr_ready(wrdy),
        .i_wr_resp_valid(wsv), .i_wr_resp_err(wse), .o_done(done), .o_err_int(eint),
        .i_reg_addr(radr), .i_reg_wdata(wdat), .i_reg_wr(rwr), .i_reg_rd(rrd),
        .o_reg_rdata(rdata));
    endpoint_model ep_u (.i_clock, .i_nrst, .i_stall(stall), .i_inject_err(inj),
        .i_rd_valid(rv), .i_wr_valid(wv), .i_rd_size(rsz), .o_rd_ready(rrdy),
        .o_rd_resp_valid(rsv), .o_rd_resp_err(rse), .o_wr_ready(wrdy),
        .o_wr_resp_valid(wsv), .o_wr_resp_err(wse), .o_rd_resp_bytes(rsb));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [40:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic model(input logic [31:0] p0, input int ab, n, st, input bit cm, rd);
        int left, sz;
        logic [31:0] p;
        if (!cm && ab <= 32 && (ab & (ab - 1)) == 0 && st == ab && n <= 1023) begin
            ab = ab * n;
            n = 1;
        end
        for (int i = 0; i < n; i++) begin
            p = p0 + i * st;
            left = ab;
            while (left > 0) begin
                sz = cm ? 32 : 32 - p % 32;
                if (sz > left) sz = left;
                if (rd) exp_rd.push_back({p, sz[8:0]});
                else exp_wr.push_back({p, sz[8:0]});
                if (!cm) p += sz;
                left -= sz;
            end
        end
    endtask
    task automatic send(input logic [31:0] s, d, input int ab, n, s1, d1, input bit s_c, d_c);
        int k = 0;
        model(s, ab, n, s1, s_c, 1);
        model(d, ab, n, d1, d_c, 0);
        @(posedge i_clock);
        {sa, da, abc, cnt, ss, ds, sc, dc, req_v} <=
            {s, d, ab[15:0], n[15:0], s1[15:0], d1[15:0], s_c, d_c, 1'b1};
        do @(negedge i_clock); while (rdy !== 1'b1 && ++k < 40000);
        @(posedge i_clock);
        req_v <= 0;
        n_sent++;
    endtask
    task automatic drain(input string name);
        for (int k = 0; k < 20000 && (exp_rd.size() || exp_wr.size() || n_done != n_sent); k++)
            @(posedge i_clock);
        chk(n_done, n_sent);
        $display("test %s finished", name);
    endtask
    task automatic wreg(input logic [7:0] ad, input logic [31:0] d);
        @(posedge i_clock);
        {radr, wdat, rwr} <= {ad, d, 1'b1};
        @(posedge i_clock);
        rwr <= 0;
    endtask
    task automatic rreg(input logic [7:0] ad, input logic [31:0] e);
        @(posedge i_clock);
        {radr, rrd} <= {ad, 1'b1};
        @(posedge i_clock);
        rrd <= 0;
        #1 chk(rdata, e);
    endtask
    always @(posedge i_clock) begin
        cyc++;
        if (rv === 1'b1 && rrdy === 1'b1) begin
            chk({raddr, rsz}, exp_rd.size() ? exp_rd.pop_front() : 41'h0);
            if (last_hs != 0 && cyc - last_hs < min_gap) min_gap = cyc - last_hs;
            if (last_hs != 0 && cyc - last_hs > max_gap) max_gap = cyc - last_hs;
            last_hs = cyc;
        end
        if (wv === 1'b1 && wrdy === 1'b1)
            chk({waddr, wsz}, exp_wr.size() ? exp_wr.pop_front() : 41'h0);
        if (done === 1'b1) n_done++;
        if (n_sent - n_done > 4) chk(n_sent - n_done, 4);
        if (eint === 1'b1) n_int++;
    end
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #250000;
        n_errors++;
        print_verdict;
    end
    initial begin
        repeat (12) @(posedge i_clock);
        i_nrst <= 1;
        rreg(`REG_READ_PACING, 32'h0);
        rreg(`REG_ERR_ENABLE, 32'h7);
        rreg(`REG_ERR_STATUS, 32'h0);
        send(31, 513, 64, 1, 64, 64, 0, 0);
        drain("unaligned");
        send(64, 192, 8, 8, 8, 10, 0, 0);
        drain("one side merged");
        send(0, 4096, 1, 1023, 1, 1, 0, 0);
        send(2048, 8192, 1, 1024, 1, 2, 0, 0);
        drain("merge count limit");
        stall <= 1;
        for (int i = 0; i < 12; i++) begin
            a = 1 + int'(rnd() % 80);
            c = 1 + int'(rnd() % 3);
            send(rnd() & 32'hFFFF, rnd() & 32'hFFFF, a, c, a, a + int'(rnd() % 2) * 4, 0, 0);
        end
        drain("pipelined random");
        stall <= 0;
        for (int p = 3; p >= 0; p -= 3) begin
            wreg(`REG_READ_PACING, p);
            {last_hs, min_gap, max_gap} = {32'd0, 32'd999, 32'd0};
            send(256, 512, 128, 1, 128, 128, 0, 0);
            drain(p ? "paced" : "unpaced");
            if (p) chk(min_gap >= 4, 1);
            else chk(max_gap <= 2, 1);
        end
        n_int = 0;
        rreg(8'h10, 32'h0);
        repeat (2) @(posedge i_clock);
        rreg(`REG_ERR_STATUS, 32'h2);
        wreg(`REG_ERR_STATUS, 32'h2);
        wreg(`REG_ERR_ENABLE, 32'h5);
        wreg(8'h14, 32'h1);
        repeat (2) @(posedge i_clock);
        rreg(`REG_ERR_STATUS, 32'h0);
        chk(n_int, 1);
        inj <= 1;
        send(0, 1024, 16, 1, 16, 16, 0, 0);
        drain("endpoint error");
        inj <= 0;
        send(64, 69, 16, 1, 16, 16, 0, 1);
        drain("misaligned constant");
        repeat (4) @(posedge i_clock);
        rreg(`REG_ERR_STATUS, 32'h5);
        chk(n_int, 3);
        wreg(`REG_ERR_STATUS, 32'h7);
        rreg(`REG_ERR_STATUS, 32'h0);
        rreg(`REG_ENGINE_STATUS, 32'h0);
        print_verdict;
    end
endmodule
